/* verilog/lec_pkg.sv */
// package: register map, field layout, reset values and timing counts for the regulator control block
// Function
// - on bit, or input-gated bits turn on
// - bits 5:4 choose one of four phases
// - voltage code 0.9V+0.1V/step, clamp 3.6V
// - switch-mode bit makes low-resistance switch
// - debounce field none/1/10/100 ms, reset 11
// - current limit, interrupt after debounce time
// - hc registers reset on Standby entry
// - reset values come from variant configuration
// - pull-down active while regulator disabled
// - hc switch always unlimited; input level only shown in status
`default_nettype none
package lec_pkg;
  // register indices; the bus byte address is four times the index
  localparam logic [7:0] LEC_IDX_R6_VSEL   = 8'h37;
  localparam logic [7:0] LEC_IDX_R6_ENA    = 8'h38;
  localparam logic [7:0] LEC_IDX_HC_VSEL   = 8'h39;
  localparam logic [7:0] LEC_IDX_HC_ENA    = 8'h3A;
  localparam logic [7:0] LEC_IDX_HC_OVL    = 8'h40;
  localparam logic [7:0] LEC_IDX_IRQ_STAT  = 8'h41;
  localparam logic [7:0] LEC_IDX_IRQ_MASK  = 8'h42;
  localparam logic [7:0] LEC_IDX_STATUS    = 8'h43;
  // field positions and masks
  localparam logic [7:0] LEC_VSEL_MASK     = 8'h3F;
  localparam logic [7:0] LEC_ENA_MASK      = 8'h3F;
  localparam logic [7:0] LEC_OVL_MASK      = 8'h03;
  localparam logic [7:0] LEC_IRQ_MASKBITS  = 8'h01;
  localparam int         LEC_SWMOD_BIT     = 5;
  localparam int         LEC_ON_BIT        = 0;
  localparam logic [4:0] LEC_VCODE_MAX     = 5'h1B;
  // reset values (variant defaults live in top parameters)
  localparam logic [1:0] LEC_OVL_RESET     = 2'h3;
  localparam logic [7:0] LEC_IRQ_MASK_RST  = 8'h00;
  // debounce times in microseconds and derived cycle counts at 100 MHz
  localparam int         LEC_CLK_MHZ       = 100;
  localparam int         LEC_DEB1_US       = 1000;
  localparam int         LEC_DEB10_US      = 10000;
  localparam int         LEC_DEB100_US     = 100000;
  localparam int         LEC_DEB1_CYC      = LEC_DEB1_US * LEC_CLK_MHZ;
  localparam int         LEC_DEB10_CYC     = LEC_DEB10_US * LEC_CLK_MHZ;
  localparam int         LEC_DEB100_CYC    = LEC_DEB100_US * LEC_CLK_MHZ;
  // apb request bundle
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } lec_apb_req_t;
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } lec_apb_rsp_t;
  // regulator phase and input conditions
  typedef struct packed {
    logic [3:0] phase;
    logic [2:0] gpin;
  } lec_cond_t;
endpackage
`default_nettype wire

/* verilog/lec_reg_on.sv */
// enable decision for one regulator from its enable register
`default_nettype none
module lec_reg_on (
  input  wire logic [7:0]    ena,
  input  wire lec_pkg::lec_cond_t cond,
  output logic               on
);
  import lec_pkg::*;
  logic [3:0] ph_sel;
  // direct bit, or gated bits with matching input, or the selected phase
  always_comb begin
    ph_sel = 4'h0;
    ph_sel[ena[5:4]] = 1'b1;
    on = ena[LEC_ON_BIT]
       | (|(ena[3:1] & cond.gpin))
       | (|(ph_sel & cond.phase));
  end
endmodule
`default_nettype wire

/* verilog/lec_top.sv */
// top: apb register bank, regulator enables, overload debounce and interrupt
//
// Our own choice: the APB slave port.
`default_nettype none
module lec_top #(
  parameter logic [7:0] R6_VSEL_RST = 8'h00,
  parameter logic [7:0] R6_ENA_RST  = 8'h00,
  parameter logic [7:0] HC_VSEL_RST = 8'h00,
  parameter logic [7:0] HC_ENA_RST  = 8'h00,
  parameter int         DEB1_CYC    = lec_pkg::LEC_DEB1_CYC,
  parameter int         DEB10_CYC   = lec_pkg::LEC_DEB10_CYC,
  parameter int         DEB100_CYC  = lec_pkg::LEC_DEB100_CYC
) (
  input  wire logic                  CLOCK,
  input  wire logic                  SRST,
  input  wire lec_pkg::lec_apb_req_t APB_REQ,
  output lec_pkg::lec_apb_rsp_t      APB_RSP,
  input  wire logic [2:0]            GP_INPUT,
  input  wire logic [3:0]            ACTIVATION_PHASE,
  input  wire logic                  STANDBY_ENTRY,
  input  wire logic                  HC_CURRENT_LIMIT,
  input  wire logic                  HC_VIN_BELOW_PROG,
  output logic                       REG6_ON,
  output logic                       REG6_SWITCH_MODE,
  output logic [4:0]                 REG6_VCODE,
  output logic                       REG6_PULLDOWN,
  output logic                       HC_ON,
  output logic                       HC_SWITCH_MODE,
  output logic                       HC_CURRENT_LIMIT_EN,
  output logic [4:0]                 HC_VCODE,
  output logic                       HC_PULLDOWN,
  output logic                       IRQ
);
  import lec_pkg::*;

  typedef struct packed {
    logic [7:0]  r6_vsel;
    logic [7:0]  r6_ena;
    logic [7:0]  hc_vsel;
    logic [7:0]  hc_ena;
    logic [7:0]  hc_ovl;
    logic [7:0]  irq_stat;
    logic [7:0]  irq_mask;
    logic [26:0] deb_cnt;
    logic        ovl_rep;
    logic [2:0]  gp_m;
    logic [2:0]  gp_s;
    logic [3:0]  ph_m;
    logic [3:0]  ph_s;
    logic [1:0]  lim_m;
    logic [1:0]  lim_s;
    logic        stby_m;
    logic        stby_s;
    logic        stby_prev;
    logic        r6_on;
    logic        hc_on;
    logic [31:0] prdata;
  } lec_state_t;

  lec_state_t s_q;
  lec_state_t s_d;
  logic       r6_on_c;
  logic       hc_on_c;
  logic [9:0] widx;
  logic       acc;
  logic       wr;
  logic       mapped;
  logic       stby_rise;
  logic       ovl_set;
  logic [26:0] deb_target;
  logic       lim_now;

  // enable decisions, inputs taken after synchronisers
  lec_reg_on u_r6 (
    .ena  (s_q.r6_ena),
    .cond (lec_cond_t'{phase: s_q.ph_s, gpin: s_q.gp_s}),
    .on   (r6_on_c)
  );
  lec_reg_on u_hc (
    .ena  (s_q.hc_ena),
    .cond (lec_cond_t'{phase: s_q.ph_s, gpin: s_q.gp_s}),
    .on   (hc_on_c)
  );

  // apb decode: index is byte address divided by four; always zero wait
  assign widx   = APB_REQ.paddr[11:2];
  assign acc    = APB_REQ.psel & APB_REQ.penable;
  assign wr     = acc & APB_REQ.pwrite;
  assign mapped = (APB_REQ.paddr[1:0] == 2'h0) &&
                  (widx == {2'h0, LEC_IDX_R6_VSEL} || widx == {2'h0, LEC_IDX_R6_ENA} ||
                   widx == {2'h0, LEC_IDX_HC_VSEL} || widx == {2'h0, LEC_IDX_HC_ENA} ||
                   widx == {2'h0, LEC_IDX_HC_OVL}  || widx == {2'h0, LEC_IDX_IRQ_STAT} ||
                   widx == {2'h0, LEC_IDX_IRQ_MASK} || widx == {2'h0, LEC_IDX_STATUS});

  assign stby_rise = s_q.stby_s & ~s_q.stby_prev;
  // limit only counts while the regulator is on and limiting is active
  assign lim_now   = s_q.lim_s[0] & s_q.hc_on & HC_CURRENT_LIMIT_EN;

  // debounce length per field code
  always_comb begin
    case (s_q.hc_ovl[1:0])
      2'h0:    deb_target = 27'h0;
      2'h1:    deb_target = 27'(DEB1_CYC - 1);
      2'h2:    deb_target = 27'(DEB10_CYC - 1);
      default: deb_target = 27'(DEB100_CYC - 1);
    endcase
  end
  // one report per continuous overload episode
  assign ovl_set = lim_now & ~s_q.ovl_rep & (s_q.deb_cnt >= deb_target);

  // next-state logic
  always_comb begin
    s_d = s_q;
    // two-stage synchronisers for all outside levels
    s_d.gp_m    = GP_INPUT;
    s_d.gp_s    = s_q.gp_m;
    s_d.ph_m    = ACTIVATION_PHASE;
    s_d.ph_s    = s_q.ph_m;
    s_d.lim_m   = {HC_VIN_BELOW_PROG, HC_CURRENT_LIMIT};
    s_d.lim_s   = s_q.lim_m;
    s_d.stby_m  = STANDBY_ENTRY;
    s_d.stby_s  = s_q.stby_m;
    s_d.stby_prev = s_q.stby_s;
    s_d.r6_on   = r6_on_c;
    s_d.hc_on   = hc_on_c;
    // overload persistence counter, restarts when the condition drops
    if (!lim_now) begin
      s_d.deb_cnt = 27'h0;
      s_d.ovl_rep = 1'b0;
    end else begin
      if (s_q.deb_cnt < deb_target) begin
        s_d.deb_cnt = s_q.deb_cnt + 27'h1;
      end
      if (ovl_set) begin
        s_d.ovl_rep = 1'b1;
      end
    end
    // register writes, reserved bits dropped
    // only a mapped, aligned index may land; upper index bits would otherwise alias
    if (wr && mapped) begin
      case (widx[7:0])
        LEC_IDX_R6_VSEL:  s_d.r6_vsel  = APB_REQ.pwdata[7:0] & LEC_VSEL_MASK;
        LEC_IDX_R6_ENA:   s_d.r6_ena   = APB_REQ.pwdata[7:0] & LEC_ENA_MASK;
        LEC_IDX_HC_VSEL:  s_d.hc_vsel  = APB_REQ.pwdata[7:0] & LEC_VSEL_MASK;
        LEC_IDX_HC_ENA:   s_d.hc_ena   = APB_REQ.pwdata[7:0] & LEC_ENA_MASK;
        LEC_IDX_HC_OVL:   s_d.hc_ovl   = APB_REQ.pwdata[7:0] & LEC_OVL_MASK;
        LEC_IDX_IRQ_STAT: s_d.irq_stat = s_q.irq_stat & ~(APB_REQ.pwdata[7:0] & LEC_IRQ_MASKBITS);
        LEC_IDX_IRQ_MASK: s_d.irq_mask = APB_REQ.pwdata[7:0] & LEC_IRQ_MASKBITS;
        default: ;
      endcase
    end
    // set after clear so a new overload in the clear cycle is kept
    if (ovl_set) begin
      s_d.irq_stat[0] = 1'b1;
    end
    // standby entry returns the high-current registers to reset values
    if (stby_rise) begin
      s_d.hc_vsel = HC_VSEL_RST & LEC_VSEL_MASK;
      s_d.hc_ena  = HC_ENA_RST & LEC_ENA_MASK;
      s_d.hc_ovl  = {6'h0, LEC_OVL_RESET};
    end
    // read data captured in setup so it is ready in the access phase
    s_d.prdata = 32'h0;
    if (APB_REQ.psel && !APB_REQ.penable && !APB_REQ.pwrite) begin
      case (widx[7:0])
        LEC_IDX_R6_VSEL:  s_d.prdata = {24'h0, s_q.r6_vsel};
        LEC_IDX_R6_ENA:   s_d.prdata = {24'h0, s_q.r6_ena};
        LEC_IDX_HC_VSEL:  s_d.prdata = {24'h0, s_q.hc_vsel};
        LEC_IDX_HC_ENA:   s_d.prdata = {24'h0, s_q.hc_ena};
        LEC_IDX_HC_OVL:   s_d.prdata = {24'h0, s_q.hc_ovl};
        LEC_IDX_IRQ_STAT: s_d.prdata = {24'h0, s_q.irq_stat};
        LEC_IDX_IRQ_MASK: s_d.prdata = {24'h0, s_q.irq_mask};
        LEC_IDX_STATUS:   s_d.prdata = {27'h0, s_q.lim_s[1], s_q.ovl_rep, lim_now, s_q.hc_on, s_q.r6_on};
        default:          s_d.prdata = 32'h0;
      endcase
      if (!mapped) begin
        s_d.prdata = 32'h0;
      end
    end
  end

  // state register; plain synchronous reset to variant defaults
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      s_q          <= '0;
      s_q.r6_vsel  <= R6_VSEL_RST & LEC_VSEL_MASK;
      s_q.r6_ena   <= R6_ENA_RST & LEC_ENA_MASK;
      s_q.hc_vsel  <= HC_VSEL_RST & LEC_VSEL_MASK;
      s_q.hc_ena   <= HC_ENA_RST & LEC_ENA_MASK;
      s_q.hc_ovl   <= {6'h0, LEC_OVL_RESET};
      s_q.irq_mask <= LEC_IRQ_MASK_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // apb answer: no wait states; unmapped or misaligned raises pslverr
  always_comb begin
    APB_RSP.pready  = 1'b1;
    APB_RSP.pslverr = acc & ~mapped;
    APB_RSP.prdata  = s_q.prdata;
  end

  // regulator controls; switch mode follows the vsel bit even while the regulator is off
  always_comb begin
    REG6_ON          = s_q.r6_on;
    REG6_SWITCH_MODE = s_q.r6_vsel[LEC_SWMOD_BIT];
    REG6_VCODE       = (s_q.r6_vsel[4:0] > LEC_VCODE_MAX) ? LEC_VCODE_MAX : s_q.r6_vsel[4:0];
    REG6_PULLDOWN    = ~s_q.r6_on;
    HC_ON            = s_q.hc_on;
    HC_SWITCH_MODE   = s_q.hc_vsel[LEC_SWMOD_BIT];
    // limiting stays on in linear mode only; switch mode turns it off whatever the input level
    HC_CURRENT_LIMIT_EN = ~s_q.hc_vsel[LEC_SWMOD_BIT];
    HC_VCODE         = (s_q.hc_vsel[4:0] > LEC_VCODE_MAX) ? LEC_VCODE_MAX : s_q.hc_vsel[4:0];
    HC_PULLDOWN      = ~s_q.hc_on;
    IRQ              = |(s_q.irq_stat & s_q.irq_mask);
  end
endmodule
`default_nettype wire

/* dv/lec_sva.sv */
// checker: port-level assertions of the regulator control block
`default_nettype none
module lec_sva (
  input wire logic                  CLOCK,
  input wire logic                  SRST,
  input wire lec_pkg::lec_apb_req_t APB_REQ,
  input wire lec_pkg::lec_apb_rsp_t APB_RSP,
  input wire logic                  HC_CURRENT_LIMIT,
  input wire logic                  REG6_ON,
  input wire logic                  REG6_PULLDOWN,
  input wire logic [4:0]            REG6_VCODE,
  input wire logic                  HC_ON,
  input wire logic                  HC_SWITCH_MODE,
  input wire logic                  HC_CURRENT_LIMIT_EN,
  input wire logic [4:0]            HC_VCODE,
  input wire logic                  HC_PULLDOWN,
  input wire logic                  IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       wr;
  logic [7:0] lim_q;
  // an apb write lands at the access edge
  assign wr = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite;
  // recent limit history: a report with no recent limit is spurious
  always_ff @(posedge CLOCK) begin
    lim_q <= SRST ? 8'h00 : {lim_q[6:0], HC_CURRENT_LIMIT};
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SRST);
  a_pd_six_off: assert property (REG6_PULLDOWN != REG6_ON) else $error("reg6 pulldown wrong");
  a_pd_hc_off: assert property (HC_PULLDOWN != HC_ON) else $error("hc pulldown wrong");
  a_six_code_max: assert property (REG6_VCODE <= 5'h1B) else $error("reg6 code too high");
  a_hc_code_max: assert property (HC_VCODE <= 5'h1B) else $error("hc code too high");
  a_hc_limit_en: assert property (HC_CURRENT_LIMIT_EN != HC_SWITCH_MODE) else $error("limit enable wrong");
  a_err_in_access: assert property (APB_RSP.pslverr |-> APB_REQ.psel && APB_REQ.penable) else $error("stray error");
  a_irq_rise_cause: assert property ($rose(IRQ) |-> $past(wr) || (|lim_q)) else $error("irq without overload");
  a_irq_fall_cause: assert property ($fell(IRQ) |-> $past(wr)) else $error("irq fell without write");
endmodule
bind lec_top lec_sva i_lec_sva (.CLOCK, .SRST, .APB_REQ, .APB_RSP, .HC_CURRENT_LIMIT, .REG6_ON, .REG6_PULLDOWN,
  .REG6_VCODE, .HC_ON, .HC_SWITCH_MODE, .HC_CURRENT_LIMIT_EN, .HC_VCODE, .HC_PULLDOWN, .IRQ);
`default_nettype wire

/* dv/lec_host.sv */
// partner: apb host model that programs the regulator registers
`default_nettype none
module lec_host (
  input  wire logic                  clock,
  output var lec_pkg::lec_apb_req_t  req,
  input  wire lec_pkg::lec_apb_rsp_t rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  // bus idle from time zero
  initial req = '0;
  // setup cycle, then access held until pready is seen at a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge clock);
    req <= '{1'b1, 1'b0, w, {2'b00, a, 2'b00}, d};
    @(posedge clock);
    req.penable <= 1'b1;
    do @(posedge clock); while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    e = rsp.pslverr;
    // released lines flip so stale address or data cannot look valid
    req <= '{1'b0, 1'b0, ~w, ~req.paddr, ~d};
  endtask
endmodule
`default_nettype wire

/* dv/lec_top_tb.sv */
// testbench: registers, enable decision, overload interrupt, standby reset
`default_nettype none
module lec_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lec_pkg::*;
  localparam int DEB [4] = '{0, 10, 20, 40};
  logic         clk = 1'b0, srst = 1'b1, stby = 1'b0, lim = 1'b0, vin = 1'b0, er;
  logic [2:0]   gp = 3'h0;
  logic [3:0]   ph = 4'h0;
  logic [31:0]  seed = 32'h4FA1CB16, rd, x, v;
  logic [4:0]   c6, ch;
  logic         on6, onh, sw6, swh, le, pd6, pdh, irq;
  int           err_total = 0, cmp_count = 0, o6, oh;
  lec_apb_req_t req;
  lec_apb_rsp_t rsp;
  // 100 MHz clock
  always #5 clk = ~clk;
  lec_top #(.DEB1_CYC(DEB[1]), .DEB10_CYC(DEB[2]), .DEB100_CYC(DEB[3])) i_lec_top (.CLOCK(clk), .SRST(srst),
    .APB_REQ(req), .APB_RSP(rsp), .GP_INPUT(gp), .ACTIVATION_PHASE(ph), .STANDBY_ENTRY(stby), .HC_CURRENT_LIMIT(lim),
    .HC_VIN_BELOW_PROG(vin), .REG6_ON(on6), .REG6_SWITCH_MODE(sw6), .REG6_VCODE(c6), .REG6_PULLDOWN(pd6),
    .HC_ON(onh), .HC_SWITCH_MODE(swh), .HC_CURRENT_LIMIT_EN(le), .HC_VCODE(ch), .HC_PULLDOWN(pdh), .IRQ(irq));
  lec_host i_lec_host (.clock(clk), .req(req), .rsp(rsp));
  // helpers: random source, compare, bus access, reference model
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    cmp_count++;
    if (seen !== ex) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_lec_host.xfer(1'b1, a, d, rd, er);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] ex, input logic ee);
    i_lec_host.xfer(1'b0, a, 32'h0, rd, er);
    chk("read data", rd, ex);
    chk("slave error", er, ee);
  endtask
  // on from direct bit, gated inputs or the selected phase
  function automatic int on_m(logic [7:0] e, logic [2:0] g, logic [3:0] p);
    return e[0] | (|(e[3:1] & g)) | p[e[5:4]];
  endfunction
  // code clamps at the 3.6 V step; switch bit passes through
  function automatic logic [5:0] vm(logic [7:0] d);
    return {d[5], (d[4:0] > 5'h1B) ? 5'h1B : d[4:0]};
  endfunction
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // watchdog: tests need under a thousand cycles, so this means a hang
  initial begin
    repeat (50000) @(posedge clk);
    err_total++;
    end_sim();
  end
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    rdc(LEC_IDX_R6_ENA, 32'h0, 1'b0);
    rdc(LEC_IDX_HC_VSEL, 32'h0, 1'b0);
    rdc(LEC_IDX_HC_OVL, 32'h3, 1'b0);
    rdc(8'h3B, 32'h0, 1'b1);
    $display("reset test done");
    for (int i = 0; i < 24; i++) begin
      x = xs();
      v = (i < 3) ? 32'h1A + i : xs();
      wr(LEC_IDX_R6_ENA, x);
      wr(LEC_IDX_HC_ENA, x[31:24]);
      wr(LEC_IDX_R6_VSEL, x[23:16]);
      wr(LEC_IDX_HC_VSEL, v);
      gp <= x[18:16];
      ph <= x[22:19];
      vin <= x[23];
      repeat (5) @(posedge clk);
      @(negedge clk);
      o6 = on_m(x[7:0], x[18:16], x[22:19]);
      oh = on_m(x[31:24], x[18:16], x[22:19]);
      chk("reg6 on", {on6, pd6}, {o6[0], !o6[0]});
      chk("hc on", {onh, pdh}, {oh[0], !oh[0]});
      chk("codes", {sw6, c6, swh, ch, le}, {vm(x[23:16]), vm(v[7:0]), !v[5]});
      rdc(LEC_IDX_HC_ENA, x[29:24], 1'b0);
      rdc(LEC_IDX_R6_VSEL, x[21:16], 1'b0);
      rdc(LEC_IDX_STATUS, {27'h0, x[23], 2'b00, oh[0], o6[0]}, 1'b0);
    end
    $display("enable test done");
    wr(LEC_IDX_HC_VSEL, 32'h0);
    wr(LEC_IDX_HC_ENA, 32'h1);
    wr(LEC_IDX_IRQ_MASK, 32'h1);
    for (int c = 0; c < 4; c++) begin
      wr(LEC_IDX_HC_OVL, c);
      lim <= 1'b1;
      if (c > 0) begin
        repeat (DEB[c] - 2) @(posedge clk);
        @(negedge clk);
        chk("irq early", irq, 1'b0);
      end
      repeat (10) @(posedge clk);
      @(negedge clk);
      chk("irq late", irq, 1'b1);
      @(posedge clk);
      lim <= 1'b0;
      wr(LEC_IDX_IRQ_STAT, 32'h1);
      @(negedge clk);
      chk("irq cleared", irq, 1'b0);
    end
    // masked event still sets status; unmasking raises the line
    wr(LEC_IDX_IRQ_MASK, 32'h0);
    wr(LEC_IDX_HC_OVL, 32'h0);
    lim <= 1'b1;
    repeat (8) @(posedge clk);
    lim <= 1'b0;
    @(negedge clk);
    chk("irq masked", irq, 1'b0);
    rdc(LEC_IDX_IRQ_STAT, 32'h1, 1'b0);
    wr(LEC_IDX_IRQ_MASK, 32'h1);
    @(negedge clk);
    chk("irq unmasked", irq, 1'b1);
    $display("overload test done");
    wr(LEC_IDX_HC_VSEL, 32'h25);
    wr(LEC_IDX_HC_OVL, 32'h1);
    wr(LEC_IDX_R6_ENA, 32'h1);
    stby <= 1'b1;
    gp <= 3'h0;
    ph <= 4'h0;
    repeat (3) @(posedge clk);
    stby <= 1'b0;
    repeat (6) @(posedge clk);
    rdc(LEC_IDX_HC_VSEL, 32'h0, 1'b0);
    rdc(LEC_IDX_HC_OVL, 32'h3, 1'b0);
    rdc(LEC_IDX_R6_ENA, 32'h1, 1'b0);
    @(negedge clk);
    chk("standby off", {onh, pdh}, 2'b01);
    $display("standby test done");
    end_sim();
  end
endmodule
`default_nettype wire
